// File: hw/mrb_defs.svh
// Register offsets, reset values and access codes of the meter register bank.
// Included by the package and by the bank; definitions only.
`ifndef MRB_DEFS_SVH
`define MRB_DEFS_SVH

`define MRB_ADDR_W            12
`define MRB_DATA_W            32

// 8-bit map
`define MRB_OFS_SAG_CYC       12'h000
`define MRB_OFS_NOLOAD_DIS    12'h001
`define MRB_OFS_LCYC_CFG      12'h004
`define MRB_OFS_V_GAIN        12'h007
`define MRB_OFS_IA_GAIN       12'h008
`define MRB_OFS_IB_GAIN       12'h009
`define MRB_OFS_WR_GUARD      12'h040
`define MRB_OFS_LAST_KIND     12'h0FD
`define MRB_OFS_UNLOCK_KEY    12'h0FE
`define MRB_OFS_LAST_BYTE     12'h0FF
`define MRB_OFS_SI_REV        12'h702
`define MRB_OFS_REF_SEL       12'h800

// 16-bit map
`define MRB_OFS_ZX_TOUT       12'h100
`define MRB_OFS_HALF_CYC      12'h101
`define MRB_OFS_MAIN_CFG      12'h102
`define MRB_OFS_PULSE1_DIV    12'h103
`define MRB_OFS_PULSE2_DIV    12'h104
`define MRB_OFS_PULSE_SEL     12'h107
`define MRB_OFS_PH_TRIM_A     12'h108
`define MRB_OFS_PH_TRIM_B     12'h109
`define MRB_OFS_PF_A          12'h10A
`define MRB_OFS_PF_B          12'h10B
`define MRB_OFS_ANGLE_A       12'h10C
`define MRB_OFS_ANGLE_B       12'h10D
`define MRB_OFS_LINE_PER      12'h10E
`define MRB_OFS_ALT_PINS      12'h110
`define MRB_OFS_TUNING        12'h120
`define MRB_OFS_LAST_ADDR     12'h1FE
`define MRB_OFS_LAST_HALF     12'h1FF

// 24/32-bit views: page 2 is the 24-bit path, page 3 the 32-bit path
`define MRB_PAGE_8            4'h0
`define MRB_PAGE_16           4'h1
`define MRB_PAGE_24           4'h2
`define MRB_PAGE_32           4'h3
`define MRB_WIDE_DEPTH        32
`define MRB_WIDE_IDX_W        5
`define MRB_OFS_LAST_WORD_LO  8'hFF

// Reset values
`define MRB_RST_8             8'h00
`define MRB_RST_LCYC_CFG      8'h40
`define MRB_RST_GAIN          3'h0
`define MRB_RST_GUARD         3'h0
`define MRB_RST_REF_SEL       1'h0
`define MRB_RST_16            16'h0000
`define MRB_RST_ZX_TOUT       16'hFFFF
`define MRB_RST_MAIN_CFG      16'h8004
`define MRB_RST_PULSE_DIV     16'h003F
`define MRB_RST_PULSE_SEL     16'h0300
`define MRB_RST_WIDE          24'h000000

// Access codes
`define MRB_KIND_READ         8'h35
`define MRB_KIND_WRITE        8'hCA
`define MRB_UNLOCK_VALUE      8'hAD

`endif

// File: hw/mrb_pkg.sv
// Types shared by the meter register bank and its users.
// Needs mrb_defs.svh on the include path.
`include "mrb_defs.svh"

package mrb_pkg;

  // Access width requested by the serial front end
  typedef enum logic [1:0] {
    MRB_SIZE_8  = 2'b00,
    MRB_SIZE_16 = 2'b01,
    MRB_SIZE_24 = 2'b10,
    MRB_SIZE_32 = 2'b11
  } mrb_size_e;

  typedef logic [`MRB_ADDR_W-1:0] mrb_addr_t;
  typedef logic [`MRB_DATA_W-1:0] mrb_data_t;

endpackage : mrb_pkg

// File: hw/mrb_bank.sv
// Register bank of a single-phase energy meter: 8/16-bit map, shared 24/32-bit store,
// last-access capture and keyed tuning register.
// Assumes a serial front end that presents one decoded access at a time, synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
`include "mrb_defs.svh"

// Contract
// - Four widths, each accessed at declared width
// - Two's complement; phase trims sign-magnitude
// - 32-bit view sign-extends low 24 bits
// - 24 and 32-bit views share storage
// - Last kind: 0x35 read, 0xCA write
// - Last data captured per access width
// - Last address of successful access kept
// - Failed accesses leave last registers unchanged
// - Tuning write needs key 0xAD first
// - Reference select: 0 internal, 1 external
// - Gain registers use low three bits
// - Write guard: three bits, reset zero
// - Half cycle count, sixteen bits, reset zero
// - Read-only fixed silicon revision
module mrb_bank #(
  parameter logic [7:0] SI_REVISION = 8'h01  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Access request from serial front end
  input  wire logic                       acc_valid,
  input  wire logic                       acc_write,
  input  wire mrb_pkg::mrb_size_e         acc_size,
  input  wire logic [`MRB_ADDR_W-1:0]     acc_addr,
  input  wire logic [`MRB_DATA_W-1:0]     acc_wdata,
  // Access answer
  output logic                            rsp_valid,
  output logic                            rsp_ok,
  output logic [`MRB_DATA_W-1:0]          rsp_rdata,
  // Measurement results from datapath
  input  wire logic [15:0]                pf_a,
  input  wire logic [15:0]                pf_b,
  input  wire logic [15:0]                angle_a,
  input  wire logic [15:0]                angle_b,
  input  wire logic [15:0]                line_period,
  // Configuration to datapath
  output logic [7:0]                      sag_cycle_count,
  output logic [7:0]                      noload_detect_disable,
  output logic [7:0]                      line_cycle_accum_config,
  output logic [2:0]                      voltage_gain_select,
  output logic [2:0]                      current_a_gain_select,
  output logic [2:0]                      current_b_gain_select,
  output logic [2:0]                      write_guard_bits,
  output logic                            reference_source_select,
  output logic [15:0]                     zero_cross_timeout,
  output logic [15:0]                     half_cycle_count,
  output logic [15:0]                     main_configuration,
  output logic [15:0]                     pulse1_divider,
  output logic [15:0]                     pulse2_divider,
  output logic [15:0]                     pulse_output_select,
  output logic [15:0]                     phase_trim_a,
  output logic [15:0]                     phase_trim_b,
  output logic [15:0]                     alternate_pin_functions,
  output logic [15:0]                     keyed_tuning_slot
);

  logic [7:0]  last_access_kind_r;
  logic [15:0] last_access_address_r;
  logic [31:0] last_data_r;
  logic        key_armed_r;
  logic [23:0] wide_mem [`MRB_WIDE_DEPTH];

  // Address class decides the declared width
  wire [3:0]  page      = acc_addr[11:8];
  wire [7:0]  low       = acc_addr[7:0];
  wire        is_sz8    = (page == `MRB_PAGE_8) || (acc_addr == `MRB_OFS_SI_REV) || (acc_addr == `MRB_OFS_REF_SEL);
  wire        is_sz16   = (page == `MRB_PAGE_16);
  wire        is_sz24   = (page == `MRB_PAGE_24);
  wire        is_sz32   = (page == `MRB_PAGE_32);
  wire        wide_hit  = (is_sz24 || is_sz32) && (low < 8'(`MRB_WIDE_DEPTH));
  wire        wide_last = (is_sz24 || is_sz32) && (low == `MRB_OFS_LAST_WORD_LO);
  wire [`MRB_WIDE_IDX_W-1:0] wide_idx = acc_addr[`MRB_WIDE_IDX_W-1:0];

  wire size_match = (is_sz8  && acc_size == mrb_pkg::MRB_SIZE_8)  ||
                    (is_sz16 && acc_size == mrb_pkg::MRB_SIZE_16) ||
                    (is_sz24 && acc_size == mrb_pkg::MRB_SIZE_24) ||
                    (is_sz32 && acc_size == mrb_pkg::MRB_SIZE_32);

  wire a_sag   = acc_addr == `MRB_OFS_SAG_CYC;
  wire a_nold  = acc_addr == `MRB_OFS_NOLOAD_DIS;
  wire a_lcyc  = acc_addr == `MRB_OFS_LCYC_CFG;
  wire a_vg    = acc_addr == `MRB_OFS_V_GAIN;
  wire a_iag   = acc_addr == `MRB_OFS_IA_GAIN;
  wire a_ibg   = acc_addr == `MRB_OFS_IB_GAIN;
  wire a_grd   = acc_addr == `MRB_OFS_WR_GUARD;
  wire a_key   = acc_addr == `MRB_OFS_UNLOCK_KEY;
  wire a_ref   = acc_addr == `MRB_OFS_REF_SEL;
  wire a_zx    = acc_addr == `MRB_OFS_ZX_TOUT;
  wire a_hcyc  = acc_addr == `MRB_OFS_HALF_CYC;
  wire a_cfg   = acc_addr == `MRB_OFS_MAIN_CFG;
  wire a_p1    = acc_addr == `MRB_OFS_PULSE1_DIV;
  wire a_p2    = acc_addr == `MRB_OFS_PULSE2_DIV;
  wire a_psel  = acc_addr == `MRB_OFS_PULSE_SEL;
  wire a_pta   = acc_addr == `MRB_OFS_PH_TRIM_A;
  wire a_ptb   = acc_addr == `MRB_OFS_PH_TRIM_B;
  wire a_alt   = acc_addr == `MRB_OFS_ALT_PINS;
  wire a_tune  = acc_addr == `MRB_OFS_TUNING;

  wire writable = a_sag || a_nold || a_lcyc || a_vg || a_iag || a_ibg || a_grd || a_key || a_ref ||
                  a_zx || a_hcyc || a_cfg || a_p1 || a_p2 || a_psel || a_pta || a_ptb || a_alt ||
                  a_tune || wide_hit;

  // Key location is write-only, so it is not readable
  wire readable_ro = (acc_addr == `MRB_OFS_LAST_KIND) || (acc_addr == `MRB_OFS_LAST_BYTE) ||
                     (acc_addr == `MRB_OFS_SI_REV) || (acc_addr == `MRB_OFS_PF_A) ||
                     (acc_addr == `MRB_OFS_PF_B) || (acc_addr == `MRB_OFS_ANGLE_A) ||
                     (acc_addr == `MRB_OFS_ANGLE_B) || (acc_addr == `MRB_OFS_LINE_PER) ||
                     (acc_addr == `MRB_OFS_LAST_ADDR) || (acc_addr == `MRB_OFS_LAST_HALF) || wide_last;
  wire readable = (writable && !a_key) || readable_ro;

  // Read-only locations and a tuning write without the key both fail
  wire wr_ok = acc_valid && acc_write && size_match && writable && (!a_tune || key_armed_r);
  wire rd_ok = acc_valid && !acc_write && size_match && readable;
  wire acc_ok = wr_ok || rd_ok;

  // Write data cut to the access width; 32-bit writes keep only the low 24 bits
  wire [23:0] wide_wdata = acc_wdata[23:0];
  wire [23:0] wide_rword = wide_mem[wide_idx];
  wire [23:0] last_lo24  = last_data_r[23:0];

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (1'b1)
      a_sag:   rd_val = {24'h000000, sag_cycle_count};
      a_nold:  rd_val = {24'h000000, noload_detect_disable};
      a_lcyc:  rd_val = {24'h000000, line_cycle_accum_config};
      a_vg:    rd_val = {29'h0, voltage_gain_select};
      a_iag:   rd_val = {29'h0, current_a_gain_select};
      a_ibg:   rd_val = {29'h0, current_b_gain_select};
      a_grd:   rd_val = {29'h0, write_guard_bits};
      a_ref:   rd_val = {31'h0, reference_source_select};
      a_zx:    rd_val = {16'h0000, zero_cross_timeout};
      a_hcyc:  rd_val = {16'h0000, half_cycle_count};
      a_cfg:   rd_val = {16'h0000, main_configuration};
      a_p1:    rd_val = {16'h0000, pulse1_divider};
      a_p2:    rd_val = {16'h0000, pulse2_divider};
      a_psel:  rd_val = {16'h0000, pulse_output_select};
      a_pta:   rd_val = {16'h0000, phase_trim_a};
      a_ptb:   rd_val = {16'h0000, phase_trim_b};
      a_alt:   rd_val = {16'h0000, alternate_pin_functions};
      a_tune:  rd_val = {16'h0000, keyed_tuning_slot};
      (acc_addr == `MRB_OFS_LAST_KIND): rd_val = {24'h000000, last_access_kind_r};
      (acc_addr == `MRB_OFS_LAST_BYTE): rd_val = {24'h000000, last_data_r[7:0]};
      (acc_addr == `MRB_OFS_SI_REV):    rd_val = {24'h000000, SI_REVISION};
      (acc_addr == `MRB_OFS_PF_A):      rd_val = {16'h0000, pf_a};
      (acc_addr == `MRB_OFS_PF_B):      rd_val = {16'h0000, pf_b};
      (acc_addr == `MRB_OFS_ANGLE_A):   rd_val = {16'h0000, angle_a};
      (acc_addr == `MRB_OFS_ANGLE_B):   rd_val = {16'h0000, angle_b};
      (acc_addr == `MRB_OFS_LINE_PER):  rd_val = {16'h0000, line_period};
      (acc_addr == `MRB_OFS_LAST_ADDR): rd_val = {16'h0000, last_access_address_r};
      (acc_addr == `MRB_OFS_LAST_HALF): rd_val = {16'h0000, last_data_r[15:0]};
      wide_hit && is_sz24:  rd_val = {8'h00, wide_rword};
      wide_hit && is_sz32:  rd_val = {{8{wide_rword[23]}}, wide_rword};
      wide_last && is_sz24: rd_val = {8'h00, last_lo24};
      wide_last && is_sz32: rd_val = {{8{last_lo24[23]}}, last_lo24};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Data captured for the last-data views, sized to the access
  wire [31:0] wr_cap = is_sz8  ? {24'h000000, acc_wdata[7:0]} :
                       is_sz16 ? {16'h0000, acc_wdata[15:0]} :
                       is_sz24 ? {8'h00, wide_wdata} : {{8{wide_wdata[23]}}, wide_wdata};
  wire [31:0] cap_nxt = acc_write ? wr_cap : rd_val;

  // Answer registered one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_ok    <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
    end else begin
      rsp_valid <= acc_valid;
      rsp_ok    <= acc_ok;
      rsp_rdata <= rd_ok ? rd_val : 32'h0000_0000;
    end
  end

  // Last-access capture only on success
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_access_kind_r    <= `MRB_RST_8;
      last_access_address_r <= `MRB_RST_16;
      last_data_r           <= 32'h0000_0000;
    end else if (acc_ok) begin
      last_access_kind_r    <= acc_write ? `MRB_KIND_WRITE : `MRB_KIND_READ;
      last_access_address_r <= {4'h0, acc_addr};
      last_data_r           <= cap_nxt;
    end
  end

  // Key arms for exactly the next successful write; any later successful write disarms it unless it writes 0xAD to the key again
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_armed_r <= 1'b0;
    end else if (wr_ok) begin
      key_armed_r <= a_key && (acc_wdata[7:0] == `MRB_UNLOCK_VALUE);
    end
  end

  // 8-bit configuration; gain, guard and reference keep only their used bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sag_cycle_count         <= `MRB_RST_8;
      noload_detect_disable   <= `MRB_RST_8;
      line_cycle_accum_config <= `MRB_RST_LCYC_CFG;
      voltage_gain_select     <= `MRB_RST_GAIN;
      current_a_gain_select   <= `MRB_RST_GAIN;
      current_b_gain_select   <= `MRB_RST_GAIN;
      write_guard_bits        <= `MRB_RST_GUARD;
      reference_source_select <= `MRB_RST_REF_SEL;
    end else if (wr_ok) begin
      if (a_sag)  sag_cycle_count         <= acc_wdata[7:0];
      if (a_nold) noload_detect_disable   <= acc_wdata[7:0];
      if (a_lcyc) line_cycle_accum_config <= acc_wdata[7:0];
      if (a_vg)   voltage_gain_select     <= acc_wdata[2:0];
      if (a_iag)  current_a_gain_select   <= acc_wdata[2:0];
      if (a_ibg)  current_b_gain_select   <= acc_wdata[2:0];
      if (a_grd)  write_guard_bits        <= acc_wdata[2:0];
      if (a_ref)  reference_source_select <= acc_wdata[0];
    end
  end

  // 16-bit configuration; dividers take every write, so a repeated write simply lands twice
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zero_cross_timeout      <= `MRB_RST_ZX_TOUT;
      half_cycle_count        <= `MRB_RST_16;
      main_configuration      <= `MRB_RST_MAIN_CFG;
      pulse1_divider          <= `MRB_RST_PULSE_DIV;
      pulse2_divider          <= `MRB_RST_PULSE_DIV;
      pulse_output_select     <= `MRB_RST_PULSE_SEL;
      phase_trim_a            <= `MRB_RST_16;
      phase_trim_b            <= `MRB_RST_16;
      alternate_pin_functions <= `MRB_RST_16;
      keyed_tuning_slot       <= `MRB_RST_16;
    end else if (wr_ok) begin
      if (a_zx)   zero_cross_timeout      <= acc_wdata[15:0];
      if (a_hcyc) half_cycle_count        <= acc_wdata[15:0];
      if (a_cfg)  main_configuration      <= acc_wdata[15:0];
      if (a_p1)   pulse1_divider          <= acc_wdata[15:0];
      if (a_p2)   pulse2_divider          <= acc_wdata[15:0];
      if (a_psel) pulse_output_select     <= acc_wdata[15:0];
      // Stored as written: the datapath decodes sign-magnitude
      if (a_pta)  phase_trim_a            <= acc_wdata[15:0];
      if (a_ptb)  phase_trim_b            <= acc_wdata[15:0];
      if (a_alt)  alternate_pin_functions <= acc_wdata[15:0];
      if (a_tune) keyed_tuning_slot       <= acc_wdata[15:0];
    end
  end

  // One 24-bit location per entry, reached by both the 24-bit and the 32-bit page
  for (genvar g = 0; g < `MRB_WIDE_DEPTH; g++) begin : g_wide
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        wide_mem[g] <= `MRB_RST_WIDE;
      end else if (wr_ok && wide_hit && wide_idx == `MRB_WIDE_IDX_W'(g)) begin
        wide_mem[g] <= wide_wdata;
      end
    end
  end

endmodule : mrb_bank
`default_nettype wire

// File: dv/mrb_bank_monitor.sv
// Checker of the meter register bank, bound to every instance of mrb_bank.
// Assumes the one-clock access contract: each taken request answered on the next edge.
`timescale 1ns/100ps
`default_nettype none
`include "mrb_defs.svh"
module mrb_bank_monitor (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Access port
  input  wire logic                       acc_valid,
  input  wire logic                       acc_write,
  input  wire mrb_pkg::mrb_size_e         acc_size,
  input  wire logic [`MRB_ADDR_W-1:0]     acc_addr,
  input  wire logic [`MRB_DATA_W-1:0]     acc_wdata,
  input  wire logic                       rsp_valid,
  input  wire logic                       rsp_ok,
  input  wire logic [`MRB_DATA_W-1:0]     rsp_rdata,
  // Datapath side
  input  wire logic [15:0]                pf_a,
  input  wire logic [2:0]                 voltage_gain_select,
  input  wire logic                       reference_source_select,
  input  wire logic [15:0]                pulse1_divider,
  input  wire logic [15:0]                keyed_tuning_slot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic rd_req = acc_valid && !acc_write;
  wire logic wr_req = acc_valid && acc_write;

  rsp_timing_a: assert property (rsp_valid == $past(acc_valid))
    else $error("answer not one cycle after request");
  size_page_a: assert property (acc_valid && acc_addr[11:8] == 4'h1 && acc_size != mrb_pkg::MRB_SIZE_16 |=>
    rsp_valid && !rsp_ok) else $error("wrong width accepted on 16-bit page");
  refuse_zero_a: assert property (rsp_valid && !rsp_ok |-> rsp_rdata == 32'h00000000)
    else $error("refused access returned data");
  wide_sign_a: assert property (rd_req && acc_size == mrb_pkg::MRB_SIZE_32 |=>
    rsp_rdata[31:24] == {8{rsp_rdata[23]}}) else $error("32-bit view not sign extended");
  narrow_zero_a: assert property (rd_req && acc_size == mrb_pkg::MRB_SIZE_24 |=>
    rsp_rdata[31:24] == 8'h00) else $error("24-bit view has upper bits set");
  gain_low_a: assert property (wr_req && acc_size == mrb_pkg::MRB_SIZE_8 && acc_addr == `MRB_OFS_V_GAIN |=>
    {29'h0, voltage_gain_select} == ($past(acc_wdata) & 32'h00000007)) else $error("gain code not taken");
  ref_pick_a: assert property (wr_req && acc_size == mrb_pkg::MRB_SIZE_8 && acc_addr == `MRB_OFS_REF_SEL |=>
    {31'h0, reference_source_select} == ($past(acc_wdata) & 32'h00000001)) else $error("reference not taken");
  divider_take_a: assert property (wr_req && acc_size == mrb_pkg::MRB_SIZE_16 && acc_addr == `MRB_OFS_PULSE1_DIV |=>
    {16'h0, pulse1_divider} == ($past(acc_wdata) & 32'h0000FFFF)) else $error("divider write not stored");
  ro_refuse_a: assert property (wr_req && acc_addr inside {[`MRB_OFS_PF_A:`MRB_OFS_LINE_PER], `MRB_OFS_LAST_ADDR,
    `MRB_OFS_LAST_HALF, `MRB_OFS_LAST_KIND, `MRB_OFS_LAST_BYTE, `MRB_OFS_SI_REV} |=> rsp_valid && !rsp_ok)
    else $error("write to read-only accepted");
  tuning_guard_a: assert property ($changed(keyed_tuning_slot) |->
    rsp_ok && $past(wr_req) && $past(acc_addr) == `MRB_OFS_TUNING) else $error("tuning slot changed without write");
  live_read_a: assert property (rd_req && acc_size == mrb_pkg::MRB_SIZE_16 && acc_addr == `MRB_OFS_PF_A |=>
    rsp_ok && rsp_rdata == {16'h0000, $past(pf_a)}) else $error("live value read wrong");

  tuning_c: cover property (wr_req && acc_addr == `MRB_OFS_TUNING ##1 rsp_ok);
  refuse_c: cover property (rsp_valid && !rsp_ok);
  wide_c: cover property (rd_req && acc_size == mrb_pkg::MRB_SIZE_32 ##1 rsp_ok);
endmodule : mrb_bank_monitor

bind mrb_bank mrb_bank_monitor u_monitor (
  .clock, .rst, .acc_valid, .acc_write, .acc_size, .acc_addr, .acc_wdata, .rsp_valid, .rsp_ok, .rsp_rdata,
  .pf_a, .voltage_gain_select, .reference_source_select, .pulse1_divider, .keyed_tuning_slot
);
`default_nettype wire

// File: dv/mrb_host.sv
// Host model of the serial front end: presents one decoded access at a time.
// Assumes the bank registers its answer on the same edge that takes the request.
`timescale 1ns/100ps
`default_nettype none
module mrb_host (
  // Clock
  input  wire logic                       clock,
  // Request
  output var  logic                       acc_valid,
  output var  logic                       acc_write,
  output var  mrb_pkg::mrb_size_e         acc_size,
  output var  logic [11:0]                acc_addr,
  output var  logic [31:0]                acc_wdata,
  // Answer
  input  wire logic                       rsp_valid,
  input  wire logic                       rsp_ok,
  input  wire logic [31:0]                rsp_rdata
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_size  = mrb_pkg::MRB_SIZE_8;
    acc_addr  = 12'h000;
    acc_wdata = 32'h00000000;
  end

  // Released address and data lines show inverted values so stale data cannot pass for a hold
  task automatic access(input logic w, input mrb_pkg::mrb_size_e sz, input logic [11:0] a,
                        input logic [31:0] d, output logic ok, output logic [31:0] rd);
    @(posedge clock);
    #1;
    acc_valid = 1'b1;
    acc_write = w;
    acc_size  = sz;
    acc_addr  = a;
    acc_wdata = d;
    @(posedge clock);
    #1;
    ok = rsp_valid & rsp_ok;
    rd = rsp_rdata;
    acc_valid = 1'b0;
    acc_addr  = ~a;
    acc_wdata = ~d;
  endtask : access
endmodule : mrb_host
`default_nettype wire

// File: dv/mrb_bank_tb.sv
// Self-checking bench of the meter register bank; every access goes through mrb_host.
// Assumes mrb_defs.svh on the include path and the checker bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module mrb_bank_tb;
  localparam mrb_pkg::mrb_size_e S8  = mrb_pkg::MRB_SIZE_8;
  localparam mrb_pkg::mrb_size_e S16 = mrb_pkg::MRB_SIZE_16;
  localparam mrb_pkg::mrb_size_e S24 = mrb_pkg::MRB_SIZE_24;
  localparam mrb_pkg::mrb_size_e S32 = mrb_pkg::MRB_SIZE_32;
  localparam logic [7:0]  SI_REV = 8'h5A;  // Arbitrary value
  localparam logic [32:0] OKW    = 33'h1_0000_0000;
  localparam logic [32:0] BAD    = 33'h0_0000_0000;
  localparam logic [11:0] DAD [19] = '{12'h0FD, 12'h000, 12'h001, 12'h004, 12'h007, 12'h008, 12'h009, 12'h040,
    12'h800, 12'h100, 12'h101, 12'h102, 12'h103, 12'h104, 12'h107, 12'h108, 12'h109, 12'h110, 12'h120};
  localparam logic [15:0] DDV [19] = '{16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h8004, 16'h003F, 16'h003F, 16'h0300, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};
  localparam logic [11:0] GAD [5]  = '{12'h007, 12'h008, 12'h009, 12'h040, 12'h800};
  localparam logic [15:0] LIVE [5] = '{16'h8123, 16'h0456, 16'hF00D, 16'h0BAD, 16'h4E20};

  logic               clock, rst, acc_valid, acc_write, rsp_valid, rsp_ok, reference_source_select;
  mrb_pkg::mrb_size_e acc_size;
  logic [11:0]        acc_addr;
  logic [31:0]        acc_wdata, rsp_rdata;
  logic [15:0]        pf_a, pf_b, angle_a, angle_b, line_period;
  logic [7:0]         sag_cycle_count, noload_detect_disable, line_cycle_accum_config;
  logic [2:0]         voltage_gain_select, current_a_gain_select, current_b_gain_select, write_guard_bits;
  logic [15:0]        zero_cross_timeout, half_cycle_count, main_configuration, pulse1_divider, pulse2_divider;
  logic [15:0]        pulse_output_select, phase_trim_a, phase_trim_b, alternate_pin_functions, keyed_tuning_slot;
  int                 num_errors, n_tests;

  mrb_bank #(.SI_REVISION(SI_REV)) dut (.*);
  mrb_host host (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Expected value holds the ok flag above the 32 data bits
  task automatic acc(input logic w, input mrb_pkg::mrb_size_e sz, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    logic        ok;
    logic [31:0] rd;
    host.access(w, sz, a, d, ok, rd);
    check({ok, rd}, exp);
  endtask : acc

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
  endtask : do_reset

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    #2000000;
    num_errors++;
    summarize();
  end

  initial begin
    num_errors = 0;
    n_tests = 0;
    {pf_a, pf_b, angle_a, angle_b, line_period} = {LIVE[0], LIVE[1], LIVE[2], LIVE[3], LIVE[4]};
    do_reset();
    for (int i = 0; i < 19; i++) begin
      acc(1'b0, mrb_pkg::mrb_size_e'(DAD[i][9:8]), DAD[i], 32'h0, {17'h1_0000, DDV[i]});
    end
    acc(1'b1, S8, 12'h702, 32'h0, BAD);
    acc(1'b0, S8, 12'h702, 32'h0, {25'h100_0000, SI_REV});
    $display("defaults test done");
    foreach (GAD[i]) begin
      acc(1'b1, S8, GAD[i], 32'hFF, OKW);
      acc(1'b0, S8, GAD[i], 32'h0, (GAD[i] == 12'h800) ? 33'h1_0000_0001 : 33'h1_0000_0007);
    end
    check({20'h0, voltage_gain_select, current_a_gain_select, current_b_gain_select, write_guard_bits,
           reference_source_select}, 33'h0_0000_1FFF);
    $display("gain test done");
    acc(1'b1, S16, 12'h101, 32'h1234, OKW);
    check({17'h0, half_cycle_count}, 33'h0_0000_1234);
    acc(1'b0, S8, 12'h0FD, 32'h0, 33'h1_0000_00CA);
    acc(1'b0, S16, 12'h1FE, 32'h0, 33'h1_0000_00FD);
    acc(1'b1, S16, 12'h10A, 32'h5, BAD);
    acc(1'b0, S8, 12'h0FD, 32'h0, 33'h1_0000_0035);
    acc(1'b0, S16, 12'h1FE, 32'h0, 33'h1_0000_00FD);
    acc(1'b1, S8, 12'h000, 32'h5A, OKW);
    acc(1'b0, S8, 12'h0FF, 32'h0, 33'h1_0000_005A);
    acc(1'b1, S16, 12'h101, 32'hABCD, OKW);
    acc(1'b0, S16, 12'h1FF, 32'h0, 33'h1_0000_ABCD);
    $display("last access test done");
    acc(1'b1, S24, 12'h205, 32'h00800001, OKW);
    acc(1'b0, S32, 12'h3FF, 32'h0, 33'h1_FF80_0001);
    acc(1'b0, S24, 12'h2FF, 32'h0, 33'h1_0080_0001);
    acc(1'b0, S32, 12'h305, 32'h0, 33'h1_FF80_0001);
    acc(1'b1, S32, 12'h305, 32'h7F123456, OKW);
    acc(1'b0, S24, 12'h205, 32'h0, 33'h1_0012_3456);
    acc(1'b0, S32, 12'h205, 32'h0, BAD);
    acc(1'b0, S8, 12'h100, 32'h0, BAD);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, S16, 12'h10A + 12'(i), 32'h0, {17'h1_0000, LIVE[i]});
    end
    $display("width test done");
    acc(1'b1, S16, 12'h120, 32'h30, BAD);
    acc(1'b1, S8, 12'h0FE, 32'hAD, OKW);
    acc(1'b0, S8, 12'h0FE, 32'h0, BAD);
    acc(1'b1, S16, 12'h120, 32'h30, OKW);
    check({17'h0, keyed_tuning_slot}, 33'h0_0000_0030);
    acc(1'b1, S16, 12'h120, 32'h31, BAD);
    acc(1'b1, S8, 12'h0FE, 32'hAC, OKW);
    acc(1'b1, S16, 12'h120, 32'h31, BAD);
    acc(1'b0, S16, 12'h120, 32'h0, 33'h1_0000_0030);
    $display("key test done");
    repeat (2) acc(1'b1, S16, 12'h103, 32'h0100, OKW);
    repeat (2) acc(1'b1, S16, 12'h104, 32'h0200, OKW);
    check({1'b0, pulse1_divider, pulse2_divider}, 33'h0_0100_0200);
    acc(1'b1, S16, 12'h108, 32'h8005, OKW);
    acc(1'b0, S16, 12'h108, 32'h0, 33'h1_0000_8005);
    acc(1'b1, S16, 12'h102, 32'h1234, OKW);
    do_reset();
    acc(1'b0, S16, 12'h102, 32'h0, 33'h1_0000_8004);
    acc(1'b0, S16, 12'h120, 32'h0, 33'h1_0000_0000);
    check({17'h0, main_configuration}, 33'h0_0000_8004);
    check({1'b0, zero_cross_timeout, pulse_output_select}, 33'h0_FFFF_0300);
    check({9'h0, sag_cycle_count, noload_detect_disable, line_cycle_accum_config}, 33'h0_0000_0040);
    check({1'b0, phase_trim_a, phase_trim_b}, 33'h0_0000_0000);
    check({1'b0, alternate_pin_functions, pulse1_divider}, 33'h0_0000_003F);
    $display("divider and reset test done");
    summarize();
  end
endmodule : mrb_bank_tb
`default_nettype wire
